// ===== core/nrc_pkg.sv
// constants shared by the receiver configuration register bank
package nrc_pkg;

	// ==========================================================
	// register offsets
	localparam logic [7:0] ADDR_FRAME_CTRL = 8'h35;
	localparam logic [7:0] ADDR_IGNORE     = 8'h36;
	localparam logic [7:0] ADDR_THRESH     = 8'h37;
	localparam logic [7:0] ADDR_INPUT      = 8'h38;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h40;
	localparam logic [7:0] ADDR_IRQ_MASK   = 8'h41;
	localparam logic [7:0] ADDR_LIVE       = 8'h42;

	// ==========================================================
	// field positions
	localparam int FC_GUARD_BIT    = 4;
	localparam int FC_SUPPRESS_BIT = 3;
	localparam int FC_RATE_LSB     = 0;
	localparam int IW_UNIT_BIT     = 7;
	localparam int TH_DECODER_LSB  = 4;
	localparam int TH_PHASE_LSB    = 0;
	localparam int IS_MODE_BIT     = 7;
	localparam int IS_CONV_BIT     = 6;
	localparam int IS_SOURCE_LSB   = 4;
	localparam int IS_COLL_LSB     = 0;
	localparam logic [7:0] IS_WRITE_MASK = 8'hF3;

	// interrupt status bits
	localparam int EV_DONE   = 0;
	localparam int EV_EMD    = 1;
	localparam int EV_GUARD  = 2;
	localparam int EV_WINDOW = 3;
	localparam logic [7:0] EV_MASK = 8'h0F;

	// ==========================================================
	// values after reset
	localparam logic [7:0] RST_FRAME_CTRL = 8'h04;
	localparam logic [7:0] RST_IGNORE     = 8'h00;
	localparam logic [7:0] RST_THRESH     = 8'h00;
	localparam logic [7:0] RST_INPUT      = 8'h00;
	localparam logic [7:0] RST_IRQ_MASK   = 8'h00;

	// ==========================================================
	// receive rate codes
	localparam logic [2:0] RATE_26  = 3'h2;
	localparam logic [2:0] RATE_52  = 3'h3;
	localparam logic [2:0] RATE_106 = 3'h4;
	localparam logic [2:0] RATE_212 = 3'h5;
	localparam logic [2:0] RATE_424 = 3'h6;
	localparam logic [2:0] RATE_847 = 3'h7;

	// ==========================================================
	// timing
	localparam int CLK_HZ     = 20_000_000;
	localparam int BAUD_26    = 26_000;
	localparam int BAUD_52    = 52_000;
	localparam int BAUD_106   = 106_000;
	localparam int BAUD_212   = 212_000;
	localparam int BAUD_424   = 424_000;
	localparam int BAUD_847   = 847_000;
	localparam logic [8:0] HALF_26  = 9'(CLK_HZ / (2 * BAUD_26));
	localparam logic [8:0] HALF_52  = 9'(CLK_HZ / (2 * BAUD_52));
	localparam logic [8:0] HALF_106 = 9'(CLK_HZ / (2 * BAUD_106));
	localparam logic [8:0] HALF_212 = 9'(CLK_HZ / (2 * BAUD_212));
	localparam logic [8:0] HALF_424 = 9'(CLK_HZ / (2 * BAUD_424));
	localparam logic [8:0] HALF_847 = 9'(CLK_HZ / (2 * BAUD_847));
	localparam int CARRIER_HZ       = 13_560_000;
	localparam int CARRIERS_PER_UNIT = 16;
	localparam logic [4:0] CARRIER_UNIT_CYC =
		5'((CARRIERS_PER_UNIT * CLK_HZ + CARRIER_HZ - 1) / CARRIER_HZ);
	localparam logic [1:0] EMD_MIN_BYTES  = 2'h3;
	localparam logic [3:0] EGT_LIMIT_BITS = 4'h6;

endpackage

// ===== core/nrc_ignore_timer.sv
// post-transmit ignore window timer
`timescale 1ns/1ps
`default_nettype none
module nrc_ignore_timer
	import nrc_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire logic       start,
	input  wire logic [6:0] count,
	input  wire logic       unit_sel,
	input  wire logic       half_tick,
	output logic            window_open,
	output logic            done
);
	logic [6:0] remain;
	logic [4:0] pre;
	wire        carrier_tick = (pre == CARRIER_UNIT_CYC - 5'h01);
	wire        unit_tick    = unit_sel ? half_tick : carrier_tick;
	wire        last         = (remain == 7'h01) && unit_tick;

	// carrier-unit prescaler, restarted with the window so units align
	always_ff @(posedge clock) begin
		if (!nrst || start || carrier_tick)
			pre <= 5'h00;
		else
			pre <= pre + 5'h01;
	end

	// down-counter loaded at end of transmission; input gated until zero
	always_ff @(posedge clock) begin
		if (!nrst) begin
			remain      <= 7'h00;
			window_open <= 1'b1;
			done        <= 1'b0;
		end else if (start) begin
			remain      <= count;
			window_open <= (count == 7'h00);
			done        <= 1'b0;
		end else begin
			done <= last;
			if (remain != 7'h00 && unit_tick)
				remain <= remain - 7'h01;
			if (last)
				window_open <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== core/nrc_emd_filter.sv
// interference suppression over the first bytes of a frame
`timescale 1ns/1ps
`default_nettype none
module nrc_emd_filter
	import nrc_pkg::*;
(
	input  wire logic clock,
	input  wire logic nrst,
	input  wire logic enable,
	input  wire logic sof,
	input  wire logic byte_ok,
	input  wire logic byte_err,
	input  wire logic frame_end,
	output logic      fifo_reset,
	output logic      emd_event,
	output logic      frame_done
);
	logic [1:0] seen;
	logic       in_frame;
	wire        early     = enable && (seen < EMD_MIN_BYTES);
	wire        early_err = byte_err && early;
	wire        short     = frame_end && in_frame && early;

	// byte counter saturates at the suppression depth
	always_ff @(posedge clock) begin
		if (!nrst) begin
			seen     <= 2'h0;
			in_frame <= 1'b0;
		end else if (sof || early_err) begin
			seen     <= 2'h0;
			in_frame <= sof || in_frame;
		end else if (frame_end) begin
			seen     <= 2'h0;
			in_frame <= 1'b0;
		end else if (byte_ok && seen != EMD_MIN_BYTES) begin
			seen <= seen + 2'h1;
		end
	end

	// early error or short frame discards data; only a short frame withholds completion
	always_ff @(posedge clock) begin
		if (!nrst) begin
			fifo_reset <= 1'b0;
			emd_event  <= 1'b0;
			frame_done <= 1'b0;
		end else begin
			fifo_reset <= early_err || short;
			emd_event  <= early_err || short;
			frame_done <= frame_end && !short;
		end
	end
endmodule
`default_nettype wire

// ===== core/nrc_rx_cfg.sv
// receiver configuration register bank with frame supervision
`timescale 1ns/1ps
`default_nettype none

module nrc_rx_cfg
	import nrc_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  wire logic       tx_end,
	input  wire logic       type_b,
	input  wire logic       rx_sof,
	input  wire logic       rx_byte,
	input  wire logic       rx_byte_err,
	input  wire logic       rx_collision,
	input  wire logic       rx_frame_end,
	output logic      [2:0] data_bit_rate,
	output logic      [3:0] decoder_min_threshold,
	output logic      [3:0] phase_min_threshold,
	output logic            single_pin_mode,
	output logic            converter_mode_sel,
	output logic      [1:0] signal_source_sel,
	output logic      [1:0] collision_sensitivity,
	output logic            collision_detect_en,
	output logic            rx_gate_open,
	output logic            fifo_reset,
	output logic            rx_done,
	output logic            protocol_error,
	output logic            irq
);
	// ==========================================================
	// register file
	logic [7:0] frame_ctrl;
	logic [7:0] ignore_cfg;
	logic [7:0] thresh;
	logic [7:0] input_sel;
	logic [7:0] irq_status;
	logic [7:0] irq_mask;

	// address decode
	wire hit_fc  = addr == ADDR_FRAME_CTRL;
	wire hit_iw  = addr == ADDR_IGNORE;
	wire hit_th  = addr == ADDR_THRESH;
	wire hit_is  = addr == ADDR_INPUT;
	wire hit_st  = addr == ADDR_IRQ_STATUS;
	wire hit_msk = addr == ADDR_IRQ_MASK;
	wire hit_lv  = addr == ADDR_LIVE;

	// field views
	wire       guard_time_check_en      = frame_ctrl[FC_GUARD_BIT];
	wire       interference_suppress_en = frame_ctrl[FC_SUPPRESS_BIT];
	wire [2:0] rate_code   = frame_ctrl[FC_RATE_LSB +: 3];
	wire       wait_unit_sel            = ignore_cfg[IW_UNIT_BIT];
	wire [6:0] ignore_window_count      = ignore_cfg[6:0];

	// frame control: every field read-write
	always_ff @(posedge clock) begin
		if (!nrst)
			frame_ctrl <= RST_FRAME_CTRL;
		else if (wr && hit_fc)
			frame_ctrl <= wdata;
	end

	// ignore window and thresholds
	always_ff @(posedge clock) begin
		if (!nrst) begin
			ignore_cfg <= RST_IGNORE;
			thresh     <= RST_THRESH;
		end else begin
			if (wr && hit_iw)
				ignore_cfg <= wdata;
			if (wr && hit_th)
				thresh <= wdata;
		end
	end

	// input select: reserved bits 3:2 stay zero
	always_ff @(posedge clock) begin
		if (!nrst)
			input_sel <= RST_INPUT;
		else if (wr && hit_is)
			input_sel <= wdata & IS_WRITE_MASK;
	end

	// ==========================================================
	// configuration outputs straight from the register bits
	assign decoder_min_threshold = thresh[TH_DECODER_LSB +: 4];
	assign phase_min_threshold   = thresh[TH_PHASE_LSB +: 4];
	assign single_pin_mode       = input_sel[IS_MODE_BIT];
	assign converter_mode_sel    = input_sel[IS_CONV_BIT];
	assign signal_source_sel     = input_sel[IS_SOURCE_LSB +: 2];
	assign collision_sensitivity = input_sel[IS_COLL_LSB +: 2];
	assign data_bit_rate         = rate_code;

	// code 3 turns the collision_detect_en output off; registered to stay a flop
	always_ff @(posedge clock) begin
		if (!nrst)
			collision_detect_en <= 1'b0;
		else
			collision_detect_en <= (input_sel[IS_COLL_LSB +: 2] != 2'h3);
	end

	// ==========================================================
	// half-bit divider; reserved rate codes leave it stopped
	logic [8:0] half_cyc;
	logic [8:0] div;
	logic       half_tick;
	logic       bit_phase;

	always_comb begin
		case (rate_code)
			RATE_26:  half_cyc = HALF_26;
			RATE_52:  half_cyc = HALF_52;
			RATE_106: half_cyc = HALF_106;
			RATE_212: half_cyc = HALF_212;
			RATE_424: half_cyc = HALF_424;
			RATE_847: half_cyc = HALF_847;
			default:  half_cyc = 9'h000;
		endcase
	end

	wire div_wrap = (half_cyc != 9'h000) && (div >= half_cyc - 9'h001);

	// a rate change mid-count just wraps early, never stalls
	always_ff @(posedge clock) begin
		if (!nrst || div_wrap)
			div <= 9'h000;
		else if (half_cyc != 9'h000)
			div <= div + 9'h001;
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			half_tick <= 1'b0;
			bit_phase <= 1'b0;
		end else begin
			half_tick <= div_wrap;
			if (div_wrap)
				bit_phase <= !bit_phase;
		end
	end

	wire bit_tick = half_tick && bit_phase;

	// ==========================================================
	// post-transmit ignore window
	logic window_open;
	logic window_done;

	nrc_ignore_timer u_timer (
		.clock       (clock),
		.nrst        (nrst),
		.start       (tx_end),
		.count       (ignore_window_count),
		.unit_sel    (wait_unit_sel),
		.half_tick   (half_tick),
		.window_open (window_open),
		.done        (window_done)
	);

	assign rx_gate_open = window_open;

	// receive events are dropped while the window is closed
	wire g_sof   = rx_sof && window_open;
	wire g_byte  = rx_byte && window_open;
	wire g_err   = (rx_byte_err || rx_collision) && window_open;
	wire g_end   = rx_frame_end && window_open;
	wire g_ok    = g_byte && !g_err;

	// ==========================================================
	// interference suppression
	logic emd_event;

	nrc_emd_filter u_emd (
		.clock      (clock),
		.nrst       (nrst),
		.enable     (interference_suppress_en),
		.sof        (g_sof),
		.byte_ok    (g_ok),
		.byte_err   (g_err),
		.frame_end  (g_end),
		.fifo_reset (fifo_reset),
		.emd_event  (emd_event),
		.frame_done (rx_done)
	);

	// ==========================================================
	// extra guard time check, counted in bit periods between bytes
	logic [3:0] gap_bits;
	logic       gap_run;
	wire        gap_long = gap_run && bit_tick && (gap_bits == EGT_LIMIT_BITS);
	wire        guard_err = guard_time_check_en && type_b && gap_long;

	always_ff @(posedge clock) begin
		if (!nrst || g_sof || g_end) begin
			gap_bits <= 4'h0;
			gap_run  <= 1'b0;
		end else if (g_byte) begin
			gap_bits <= 4'h0;
			gap_run  <= 1'b1;
		end else if (gap_long) begin
			gap_run <= 1'b0;
		end else if (gap_run && bit_tick) begin
			gap_bits <= gap_bits + 4'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst)
			protocol_error <= 1'b0;
		else if (guard_err)
			protocol_error <= 1'b1;  // set wins over a new start
		else if (g_sof)
			protocol_error <= 1'b0;
	end

	// ==========================================================
	// interrupt status: read clears, a new event in that cycle wins
	wire [7:0] events = {4'h0, window_done, guard_err, emd_event, rx_done};
	wire       st_rd  = rd && hit_st;

	always_ff @(posedge clock) begin
		if (!nrst)
			irq_status <= 8'h00;
		else
			irq_status <= (st_rd ? 8'h00 : irq_status) | events;
	end

	always_ff @(posedge clock) begin
		if (!nrst)
			irq_mask <= RST_IRQ_MASK;
		else if (wr && hit_msk)
			irq_mask <= wdata & EV_MASK;
	end

	// one cycle behind status; keeps the pin a clean flop output
	always_ff @(posedge clock) begin
		if (!nrst)
			irq <= 1'b0;
		else
			irq <= |(irq_status & irq_mask);
	end

	// ==========================================================
	// read path; unmapped addresses answer zero
	wire [7:0] live = {4'h0, collision_detect_en, protocol_error,
		half_cyc != 9'h000, window_open};
	wire [7:0] rd_mux =
		hit_fc  ? frame_ctrl :
		hit_iw  ? ignore_cfg :
		hit_th  ? thresh :
		hit_is  ? input_sel :
		hit_st  ? irq_status :
		hit_msk ? irq_mask :
		hit_lv  ? live : 8'h00;

	always_ff @(posedge clock) begin
		if (!nrst)
			rdata <= 8'h00;
		else if (rd)
			rdata <= rd_mux;
		else
			rdata <= 8'h00;
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	chk_fc_write: assert property (
		wr && hit_fc |=> frame_ctrl == $past(wdata))
		else $error("frame control write lost");
	chk_rfu_zero: assert property (
		input_sel[3:2] == 2'h0)
		else $error("input select reserved bits set");
	chk_coll_off: assert property (
		input_sel[1:0] == 2'h3 |=> !collision_detect_en)
		else $error("collision detect not disabled");
	chk_gate_closed: assert property (
		tx_end && ignore_window_count != 7'h00 |=> !rx_gate_open)
		else $error("window did not close after transmit");
	chk_gate_min: assert property (
		tx_end && ignore_window_count == 7'h01 && !wait_unit_sel
		|=> !rx_gate_open [*8])
		else $error("carrier window ended too soon");
	chk_gate_reopen: assert property (
		tx_end && ignore_window_count == 7'h01 && !wait_unit_sel
		|-> ##[1:30] rx_gate_open)
		else $error("carrier window never reopened");
	chk_early_err: assert property (
		interference_suppress_en && g_err && u_emd.seen == 2'h0 |=> fifo_reset)
		else $error("early error did not reset fifo");
	chk_emd_noflag: assert property (
		emd_event |-> !rx_done)
		else $error("completion raised on interference");
	chk_guard: assert property (
		protocol_error && !$past(protocol_error) |->
		$past(guard_time_check_en) && $past(type_b))
		else $error("guard error without check enabled");
	chk_st_sticky: assert property (
		rx_done && !st_rd |=> irq_status[EV_DONE])
		else $error("done event not latched");
	chk_rd_data: assert property (
		rd && hit_th |=> rdata == $past(thresh))
		else $error("threshold readback wrong");

	cov_emd: cover property (emd_event);
	cov_done: cover property (rx_done && irq_status[EV_DONE] == 1'b0);
	cov_guard: cover property (guard_err);
	cov_window: cover property (window_done);
endmodule
`default_nettype wire

// ===== testbench/nfc_receiver_config_regs_tb_top.sv
// self-checking bench for the receiver configuration register bank
`timescale 1ns/1ps
`default_nettype none
module nfc_receiver_config_regs_tb_top;
	import nrc_pkg::*;

	// ==========================================================
	// stimulus pulses packed as tx_end, sof, byte, err, coll, end
	localparam logic [5:0] P_TX   = 6'h20;
	localparam logic [5:0] P_SOF  = 6'h10;
	localparam logic [5:0] P_BYTE = 6'h08;
	localparam logic [5:0] P_ERR  = 6'h04;
	localparam logic [5:0] P_COLL = 6'h02;
	localparam logic [5:0] P_FEND = 6'h01;

	logic       clock, nrst, wr, rd, type_b;
	logic [7:0] addr, wdata, rdata;
	logic [5:0] ev_v;
	logic [2:0] rate;
	logic [3:0] dec_th, ph_th;
	logic [1:0] src, coll_s;
	logic       single, conv, coll_en, gate, fifo_reset, rx_done, perr, irq;
	logic [7:0] mdl [256];
	logic [7:0] msk;
	int         error_cnt, n_compared, n_fr, n_done;

	nrc_rx_cfg nrc_rx_cfg_i (
		.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .tx_end(ev_v[5]), .type_b(type_b), .rx_sof(ev_v[4]),
		.rx_byte(ev_v[3]), .rx_byte_err(ev_v[2]), .rx_collision(ev_v[1]),
		.rx_frame_end(ev_v[0]), .data_bit_rate(rate), .decoder_min_threshold(dec_th),
		.phase_min_threshold(ph_th), .single_pin_mode(single), .converter_mode_sel(conv),
		.signal_source_sel(src), .collision_sensitivity(coll_s),
		.collision_detect_en(coll_en), .rx_gate_open(gate), .fifo_reset(fifo_reset),
		.rx_done(rx_done), .protocol_error(perr), .irq(irq)
	);

	// ==========================================================
	// clock and pulse counters
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	always @(posedge clock) begin
		if (fifo_reset === 1'b1) n_fr++;
		if (rx_done === 1'b1) n_done++;
	end

	// writable bits per address; 0x38 bits 3:2 are reserved
	function automatic logic [7:0] wmask(input logic [7:0] a);
		case (a)
			ADDR_FRAME_CTRL, ADDR_IGNORE, ADDR_THRESH: return 8'hFF;
			ADDR_INPUT:    return 8'hF3;
			ADDR_IRQ_MASK: return 8'h0F;
			default:       return 8'h00;
		endcase
	endfunction

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		mdl[a] = d & wmask(a);
	endtask

	// rdata stands only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		@(posedge clock);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		rd_reg(a, v);
		chk($sformatf("reg %h", a), v, e);
	endtask

	task automatic ev(input logic [5:0] v);
		@(posedge clock);
		ev_v <= v;
		@(posedge clock);
		ev_v <= 6'h00;
	endtask

	// one frame; bad is the index of a faulty byte, -1 for none
	task automatic frame(input bit sup, input int nb, input int bad, input bit cl);
		int  f0, d0;
		bit  early, emd;
		logic [7:0] v, st;
		wr_reg(ADDR_FRAME_CTRL, sup ? 8'h0C : 8'h04);
		rd_reg(ADDR_IRQ_STATUS, v);
		f0 = n_fr;
		d0 = n_done;
		early = sup && bad >= 0 && bad < 3;
		emd = early || (sup && nb < 3);
		st = emd ? 8'h02 : 8'h01;
		ev(P_SOF); // the FIFO is never read before three bytes
		for (int i = 0; i < nb; i++) ev(i == bad ? (cl ? P_COLL : P_ERR) : P_BYTE);
		if (!early) ev(P_FEND);
		repeat (3) @(posedge clock);
		#1 chk("fifo_reset", 8'(n_fr - f0), 8'(emd));
		chk("rx_done", 8'(n_done - d0), 8'(!emd));
		chk("irq", 8'(irq), 8'(|(st & msk)));
		rd_chk(ADDR_IRQ_STATUS, st);
		repeat (2) @(posedge clock);
		#1 chk("irq clear", 8'(irq), 8'h00);
	endtask

	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// watchdog well beyond the expected run of under two thousand cycles
	initial begin
		#(40_000 * 50);
		error_cnt++;
		print_verdict();
	end

	// ==========================================================
	// main sequence
	initial begin : main
		logic [7:0] al [7] = '{8'h35, 8'h36, 8'h37, 8'h38, 8'h40, 8'h41, 8'h50};
		int         wt [4][4] = '{'{0, 8'h03, 68, 76}, '{0, 8'h01, 20, 28},
			'{7, 8'h85, 42, 59}, '{6, 8'h84, 67, 96}};
		logic [7:0] d;
		int         n;
		nrst = 1'b0; addr = 8'h00; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
		ev_v = 6'h00; type_b = 1'b0; msk = 8'h00;
		error_cnt = 0; n_compared = 0; n_fr = 0; n_done = 0;
		for (int a = 0; a < 256; a++) mdl[a] = 8'h00;
		mdl[8'h35] = 8'h04;
		void'($urandom(32'hC57392D1));
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		#1 chk("rate", 8'(rate), 8'h04);
		chk("gate", 8'(gate), 8'h01);
		foreach (al[i]) rd_chk(al[i], mdl[al[i]]);
		$display("test reset done");

		// random values, reserved bits and read-only places
		repeat (6) foreach (al[i]) begin
			wr_reg(al[i], 8'($urandom()));
			rd_chk(al[i], mdl[al[i]]);
		end
		#1 chk("dec", 8'(dec_th), 8'(mdl[8'h37][7:4]));
		chk("phase", 8'(ph_th), 8'(mdl[8'h37][3:0]));
		chk("input", {single, conv, src, 4'h0}, mdl[8'h38] & 8'hF0);
		for (int c = 0; c < 4; c++) begin
			wr_reg(ADDR_INPUT, 8'(c));
			@(posedge clock);
			#1 chk("coll_en", 8'(coll_en), 8'(c != 3));
			chk("coll", 8'(coll_s), 8'(c));
		end
		for (int c = 0; c < 8; c++) begin
			wr_reg(ADDR_FRAME_CTRL, 8'(c));
			#1 chk("rate code", 8'(rate), 8'(c));
			rd_chk(ADDR_LIVE, {6'h00, c >= 2, 1'b1});
		end
		$display("test registers done");

		// ignore window length in both units, inputs refused meanwhile
		foreach (wt[i]) begin
			wr_reg(ADDR_FRAME_CTRL, 8'(wt[i][0]));
			wr_reg(ADDR_IGNORE, 8'(wt[i][1]));
			rd_reg(ADDR_IRQ_STATUS, d);
			ev(P_TX);
			#1 chk("gate shut", 8'(gate), 8'h00);
			ev(P_SOF);
			ev(P_FEND);
			// look past the edge; four cycles since tx_end was taken
			#1 n = 4;
			while (gate !== 1'b1 && n < 5000) begin
				@(posedge clock);
				#1 n++;
			end
			chk("window", 8'(n >= wt[i][2] && n <= wt[i][3]), 8'h01);
			rd_chk(ADDR_IRQ_STATUS, 8'h08);
		end
		wr_reg(ADDR_IGNORE, 8'h00);
		ev(P_TX);
		repeat (2) @(posedge clock);
		#1 chk("gate zero", 8'(gate), 8'h01);
		$display("test window done");

		// interference suppression, with and without the interrupt mask
		msk = mdl[ADDR_IRQ_MASK];
		for (int m = 0; m < 2; m++) begin
			frame(1, 1, 0, 0);
			frame(1, 2, 1, 1);
			frame(1, 2, -1, 0);
			frame(1, 3, -1, 0);
			frame(1, 4, 3, 0);
			frame(0, 2, 0, 0);
			wr_reg(ADDR_IRQ_MASK, 8'h02);
			msk = 8'h02;
		end
		$display("test frames done");

		// guard time only for Type B with the check on
		for (int g = 1; g < 4; g++) begin
			wr_reg(ADDR_FRAME_CTRL, {3'h0, g[0], 1'b0, 3'h7});
			type_b <= g[1];
			rd_reg(ADDR_IRQ_STATUS, d);
			ev(P_SOF);
			ev(P_BYTE);
			repeat (300) @(posedge clock);
			#1 chk("perr", 8'(perr), 8'(g == 3));
			rd_chk(ADDR_IRQ_STATUS, g == 3 ? 8'h04 : 8'h00);
			ev(P_SOF);
			@(posedge clock);
			#1 chk("perr clear", 8'(perr), 8'h00);
		end
		$display("test guard done");
		print_verdict();
	end
endmodule
`default_nettype wire
